// [accal_alu.sv]
// Accumulator ALU with add, AND, bit clear/set and bit test with skip,
// its working register, flags and data register file, behind AXI4-Lite.
// Assumes one master with at most one write and one read under way.
`timescale 1ns/10ps
`default_nettype none
`include "accal_defs.svh"

// What this block does
// - add_immediate_to_acc adds 8-bit immediate to accumulator; carry, digit carry, zero updated.
// - add_acc_to_reg adds register to accumulator; destination bit picks target.
// - and_immediate_with_acc ANDs immediate into accumulator; only zero updated.
// - and_acc_with_reg with destination 0 writes accumulator; only zero updated.
// - and_acc_with_reg with destination 1 writes register; accumulator kept.
// - bit_clear_reg clears one bit of a register; flags untouched.
// - bit_set_reg sets one bit of a register; flags untouched.
// - bit_test_skip_when_zero on a one bit: next instruction runs normally.
// - On a zero bit the next instruction becomes a no-operation: two cycles.
module accal_alu import accal_pkg::*; #(
  parameter int FILE_AW = 7
) (
  input wire logic clock, // Core clock
  input wire logic reset, // Async reset, high
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [7:0] acc_out, // Working register
  output logic skip_pending // Next command will be discarded
);

  localparam int FILE_DEPTH = 1 << FILE_AW;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bit_mask(input logic [2:0] pos);
    bit_mask = 8'h01 << pos;
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic carry_r;
  logic carry_nxt;
  logic dcarry_r;
  logic dcarry_nxt;
  logic zero_r;
  logic zero_nxt;
  logic skip_r;
  logic skip_nxt;
  logic [7:0] res_r;
  logic [15:0] cyc_r;
  logic [7:0] file_r [0:FILE_DEPTH-1];
  logic awready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // ----------------------------------------------------------------
  // Write channel decode
  // ----------------------------------------------------------------
  // Address and data are taken together; holding ready low until both
  // are present is legal and keeps the slave free of a skid buffer.
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
  wire wr_hs = awready_r & s_axi_awvalid & s_axi_wvalid;
  wire [11:0] aw_off = s_axi_awaddr;
  wire aw_file = aw_off[`ACCAL_WIN_HI:`ACCAL_WIN_LO] == `ACCAL_FILE_SEL;
  wire aw_cmd = aw_off == `ACCAL_OFF_CMD;
  wire aw_acc = aw_off == `ACCAL_OFF_ACC;
  wire aw_stat = aw_off == `ACCAL_OFF_STAT;
  wire aw_ro = (aw_off == `ACCAL_OFF_RES) | (aw_off == `ACCAL_OFF_CYC);
  wire aw_map = aw_file | aw_cmd | aw_acc | aw_stat | aw_ro;
  wire lane0 = s_axi_wstrb[0];
  wire [FILE_AW-1:0] aw_idx = aw_off[`ACCAL_IDX_LSB +: FILE_AW];

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire exec = wr_hs & aw_cmd & lane0;
  wire accal_op_t op_raw = accal_op_t'(s_axi_wdata[`ACCAL_CMD_OP]);
  // A discarded command still takes its cycle, as a no-operation
  wire accal_op_t op = skip_r ? OP_NOP : op_raw;
  wire dst = s_axi_wdata[`ACCAL_CMD_DST];
  wire [2:0] bsel = s_axi_wdata[`ACCAL_CMD_BIT];
  wire [FILE_AW-1:0] fsel = s_axi_wdata[`ACCAL_CMD_REG_LSB +: FILE_AW];
  wire [7:0] imm = s_axi_wdata[`ACCAL_CMD_IMM];
  wire [7:0] fval = file_r[fsel];

  wire use_imm = (op == OP_ADD_IMM) | (op == OP_AND_IMM);
  wire is_add = (op == OP_ADD_IMM) | (op == OP_ADD_REG);
  wire is_and = (op == OP_AND_IMM) | (op == OP_AND_REG);
  wire reg_op = (op == OP_ADD_REG) | (op == OP_AND_REG);
  wire is_bitw = (op == OP_BIT_CLR) | (op == OP_BIT_SET);

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  wire [7:0] opnd = use_imm ? imm : fval;
  wire [8:0] sum9 = {1'b0, acc_r} + {1'b0, opnd};
  wire [4:0] nib5 = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]};
  wire [7:0] andv = acc_r & opnd;
  wire [7:0] mask = bit_mask(bsel);
  wire [7:0] clrv = fval & ~mask;
  wire [7:0] setv = fval | mask;
  // Nop and bit test fall through to the set value; only the result register sees it
  wire [7:0] result = is_add ? sum9[7:0] : (is_and ? andv : ((op == OP_BIT_CLR) ? clrv : setv));

  // Destination select: 0 to accumulator, 1 back to the register
  wire to_acc = use_imm | (reg_op & ~dst);
  wire to_file = is_bitw | (reg_op & dst);
  wire test_skip = (op == OP_BIT_TEST) & is_zero(fval & mask);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  wire acc_wr = wr_hs & aw_acc & lane0;
  wire stat_wr = wr_hs & aw_stat & lane0;

  always_comb begin
    acc_nxt = acc_r;
    if (exec & to_acc) begin
      acc_nxt = result;
    end else if (acc_wr) begin
      acc_nxt = s_axi_wdata[7:0];
    end
  end

  // Bit ops and the bit test leave carry, digit carry and zero alone
  always_comb begin
    carry_nxt = carry_r;
    dcarry_nxt = dcarry_r;
    zero_nxt = zero_r;
    if (exec & is_add) begin
      carry_nxt = sum9[`ACCAL_BYTE_CARRY];
      dcarry_nxt = nib5[`ACCAL_NIB_CARRY];
      zero_nxt = is_zero(result);
    end else if (exec & is_and) begin
      zero_nxt = is_zero(result);
    end else if (stat_wr) begin
      carry_nxt = s_axi_wdata[`ACCAL_ST_C];
      dcarry_nxt = s_axi_wdata[`ACCAL_ST_DIGIT];
      zero_nxt = s_axi_wdata[`ACCAL_ST_Z];
    end
  end

  // Any executed command clears a pending skip; a failing test arms it
  assign skip_nxt = exec ? test_skip : skip_r;

  wire file_we = (exec & to_file) | (wr_hs & aw_file & lane0);
  wire [FILE_AW-1:0] file_wa = exec ? fsel : aw_idx;
  wire [7:0] file_wd = exec ? result : s_axi_wdata[7:0];

  // ----------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------
  // Flags reset clear; software may preset carry, digit carry and zero through the status word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acc_r <= `ACCAL_RST_BYTE;
      carry_r <= 1'b0;
      dcarry_r <= 1'b0;
      zero_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      dcarry_r <= dcarry_nxt;
      zero_r <= zero_nxt;
      skip_r <= skip_nxt;
    end
  end

  // Every executed command, discarded ones too, counts one cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      res_r <= `ACCAL_RST_BYTE;
      cyc_r <= `ACCAL_RST_CYC;
    end else if (exec) begin
      res_r <= result;
      cyc_r <= cyc_r + 16'h0001;
    end
  end

  // Clearing the whole file on reset costs area but keeps every read defined
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_r[i] <= `ACCAL_RST_BYTE;
      end
    end else if (file_we) begin
      file_r[file_wa] <= file_wd;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  // An unmapped address is answered with an error rather than left hanging
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `ACCAL_RESP_OKAY;
    end else begin
      awready_r <= wr_go;
      if (wr_hs) begin
        bvalid_r <= 1'b1;
        bresp_r <= aw_map ? `ACCAL_RESP_OKAY : `ACCAL_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire rd_go = s_axi_arvalid & ~arready_r & ~rvalid_r;
  wire rd_hs = arready_r & s_axi_arvalid;
  wire [11:0] ar_off = s_axi_araddr;
  wire ar_file = ar_off[`ACCAL_WIN_HI:`ACCAL_WIN_LO] == `ACCAL_FILE_SEL;
  wire [FILE_AW-1:0] ar_idx = ar_off[`ACCAL_IDX_LSB +: FILE_AW];
  wire [3:0] stat_v = {skip_r, zero_r, dcarry_r, carry_r};
  wire ar_map = ar_file | (ar_off == `ACCAL_OFF_CMD) | (ar_off == `ACCAL_OFF_ACC) |
                (ar_off == `ACCAL_OFF_STAT) | (ar_off == `ACCAL_OFF_RES) | (ar_off == `ACCAL_OFF_CYC);
  logic [31:0] rd_mux;

  // The command word reads as zero; it only triggers execution
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ar_file) begin
      rd_mux = {24'h000000, file_r[ar_idx]};
    end else if (ar_off == `ACCAL_OFF_ACC) begin
      rd_mux = {24'h000000, acc_r};
    end else if (ar_off == `ACCAL_OFF_STAT) begin
      rd_mux = {28'h0000000, stat_v};
    end else if (ar_off == `ACCAL_OFF_RES) begin
      rd_mux = {24'h000000, res_r};
    end else if (ar_off == `ACCAL_OFF_CYC) begin
      rd_mux = {16'h0000, cyc_r};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `ACCAL_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      // Read data is captured at the address handshake; later writes do not alter it
      arready_r <= rd_go;
      if (rd_hs) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= ar_map ? `ACCAL_RESP_OKAY : `ACCAL_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flip-flop, so the bus never sees decode glitches
  assign s_axi_awready = awready_r;
  assign s_axi_wready = awready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign acc_out = acc_r;
  assign skip_pending = skip_r;

endmodule // accal_alu
`default_nettype wire

// [accal_defs.svh]
// Offsets, field positions and reset values of the accumulator ALU block.
// Assumes inclusion by bare name from the design file.
`ifndef ACCAL_DEFS_SVH
`define ACCAL_DEFS_SVH
// Byte offsets on the register bus
`define ACCAL_OFF_CMD 12'h000
`define ACCAL_OFF_ACC 12'h004
`define ACCAL_OFF_STAT 12'h008
`define ACCAL_OFF_RES 12'h00c
`define ACCAL_OFF_CYC 12'h010
// Data register window 0x200..0x3fc, one byte per word
`define ACCAL_FILE_SEL 3'h1
`define ACCAL_WIN_HI 11
`define ACCAL_WIN_LO 9
`define ACCAL_IDX_LSB 2
// Command word fields
`define ACCAL_CMD_OP 2:0
`define ACCAL_CMD_DST 3
`define ACCAL_CMD_BIT 6:4
`define ACCAL_CMD_REG_LSB 8
`define ACCAL_CMD_IMM 23:16
// Status word bits
`define ACCAL_ST_C 0
`define ACCAL_ST_DIGIT 1
`define ACCAL_ST_Z 2
`define ACCAL_ST_SKIP 3
// Carry-out positions of the add
`define ACCAL_NIB_CARRY 4
`define ACCAL_BYTE_CARRY 8
// Reset values and bus answers
`define ACCAL_RST_BYTE 8'h00
`define ACCAL_RST_CYC 16'h0000
`define ACCAL_RESP_OKAY 2'h0
`define ACCAL_RESP_SLVERR 2'h2
`endif

// [accal_pkg.sv]
// Types shared by the accumulator ALU block.
// Assumes nothing of its surroundings.
`default_nettype none
package accal_pkg;
  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_ADD_IMM = 3'b001,
    OP_ADD_REG = 3'b010,
    OP_AND_IMM = 3'b011,
    OP_AND_REG = 3'b100,
    OP_BIT_CLR = 3'b101,
    OP_BIT_SET = 3'b110,
    OP_BIT_TEST = 3'b111
  } accal_op_t;
endpackage
`default_nettype wire

// [accal_axi_mst.sv]
// AXI4-Lite master standing in for the instruction sequencer and host.
// Assumes a slave that answers every request; the bench watchdog cuts a hang.
`timescale 1ns/10ps
`default_nettype none
module accal_axi_mst (
  input wire logic clock, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  output logic [11:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r, input logic [3:0] s = 4'hf);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    // Released lines show garbage so a stale value cannot pass
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    do @(posedge clock); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // accal_axi_mst
`default_nettype wire

// [accal_alu_chk.sv]
// Checker for the accumulator ALU ports, bound to accal_alu.
// Assumes the command register sits at the offset in accal_defs.svh.
`timescale 1ns/10ps
`default_nettype none
`include "accal_defs.svh"
module accal_chk (
  input wire logic clock, reset,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, skip_pending,
  input wire logic [7:0] acc_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire logic wr_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  wire logic cmd_take = wr_take && s_axi_awaddr == `ACCAL_OFF_CMD && s_axi_wstrb[0];
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
  a_w_pair: assert property (s_axi_awready == s_axi_wready) else $error("awready and wready differ");
  a_aw_cause: assert property ($rose(s_axi_awready) |-> $past(s_axi_awvalid && s_axi_wvalid))
    else $error("write ready without request");
  a_b_follow: assert property (wr_take |=> s_axi_bvalid) else $error("no write answer");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready too long");
  a_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready && s_axi_arvalid))
    else $error("read answer without request");
  a_acc_cause: assert property (!wr_take |=> $stable(acc_out)) else $error("acc moved alone");
  a_skip_clear: assert property (skip_pending && cmd_take |=> !skip_pending)
    else $error("skip not cleared");
  a_skip_nop: assert property (skip_pending && cmd_take |=> $stable(acc_out))
    else $error("discarded command changed acc");
  a_skip_cause: assert property ($rose(skip_pending) |-> $past(cmd_take))
    else $error("skip without command");
  c_skip: cover property (skip_pending && cmd_take);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // accal_chk
bind accal_alu accal_chk i_chk (.*);
`default_nettype wire

// [tb_accum_alu_bit_ops.sv]
// Self-checking bench: register accesses and commands over AXI4-Lite.
// Assumes accal_pkg, accal_alu, accal_axi_mst and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "accal_defs.svh"
module tb_accum_alu_bit_ops import accal_pkg::*;;
  localparam logic [11:0] R5 = 12'h214, R6 = 12'h218, R127 = 12'h3fc;
  logic clock, reset, skip_pending;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] acc_out;
  int errors = 0;
  int checked = 0;
  accal_alu i_dut (.*);
  accal_axi_mst i_mst (.*);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic put(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = `ACCAL_RESP_OKAY);
    i_mst.wr(a, d, resp);
    cmp({30'h0, resp}, {30'h0, er}, "write resp");
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = `ACCAL_RESP_OKAY);
    i_mst.rd(a, rd_data, resp);
    cmp(rd_data, e, "read data");
    cmp({30'h0, resp}, {30'h0, er}, "read resp");
  endtask
  function automatic logic [31:0] cw(accal_op_t op, logic d, logic [2:0] b, logic [6:0] f, logic [7:0] k);
    return {8'h00, k, 1'b0, f, 1'b0, b, d, op};
  endfunction
  // Preset status and acc, issue one command, read both back
  task automatic run(input logic [7:0] st, a, input logic [31:0] c, input logic [7:0] ea, est);
    put(`ACCAL_OFF_STAT, {24'h0, st});
    put(`ACCAL_OFF_ACC, {24'h0, a});
    put(`ACCAL_OFF_CMD, c);
    cmp({24'h0, acc_out}, {24'h0, ea}, "acc port");
    chk(`ACCAL_OFF_ACC, {24'h0, ea});
    chk(`ACCAL_OFF_STAT, {24'h0, est});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    chk(`ACCAL_OFF_ACC, 32'h0);
    chk(`ACCAL_OFF_STAT, 32'h0);
    chk(R5, 32'h0);
    chk(12'h020, 32'h0, `ACCAL_RESP_SLVERR);
    put(12'h020, 32'h1, `ACCAL_RESP_SLVERR);
    put(R5, 32'h3c);
    put(R127, 32'hff);
    $display("test reset and map done");
    run(8'h00, 8'h88, cw(OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h78), 8'h00, 8'h07);
    run(8'h07, 8'h01, cw(OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h0e), 8'h0f, 8'h00);
    run(8'h00, 8'h0f, cw(OP_ADD_REG, 1'b1, 3'h0, 7'h05, 8'h00), 8'h0f, 8'h02);
    chk(R5, 32'h4b);
    chk(`ACCAL_OFF_RES, 32'h4b);
    run(8'h00, 8'h01, cw(OP_ADD_REG, 1'b0, 3'h0, 7'h7f, 8'h00), 8'h00, 8'h07);
    chk(R127, 32'hff);
    $display("test add done");
    run(8'h03, 8'hf0, cw(OP_AND_IMM, 1'b0, 3'h0, 7'h00, 8'h0f), 8'h00, 8'h07);
    run(8'h07, 8'hff, cw(OP_AND_REG, 1'b0, 3'h0, 7'h05, 8'h00), 8'h4b, 8'h03);
    run(8'h00, 8'h0f, cw(OP_AND_REG, 1'b1, 3'h0, 7'h05, 8'h00), 8'h0f, 8'h00);
    chk(R5, 32'h0b);
    $display("test and done");
    run(8'h05, 8'h11, cw(OP_BIT_CLR, 1'b0, 3'h3, 7'h05, 8'h00), 8'h11, 8'h05);
    chk(R5, 32'h03);
    run(8'h06, 8'h22, cw(OP_BIT_SET, 1'b0, 3'h7, 7'h05, 8'h00), 8'h22, 8'h06);
    chk(R5, 32'h83);
    for (int b = 0; b < 8; b++) begin
      put(`ACCAL_OFF_CMD, cw(OP_BIT_CLR, 1'b0, b[2:0], 7'h7f, 8'h00));
      chk(R127, {24'h0, 8'hfe << b});
      put(`ACCAL_OFF_CMD, cw(OP_BIT_SET, 1'b0, b[2:0], 7'h06, 8'h00));
      chk(R6, {24'h0, 8'hff ^ (8'hfe << b)});
    end
    chk(`ACCAL_OFF_STAT, 32'h6);
    $display("test bit ops done");
    run(8'h00, 8'h00, cw(OP_BIT_TEST, 1'b0, 3'h0, 7'h05, 8'h00), 8'h00, 8'h00);
    cmp({31'h0, skip_pending}, 32'h0, "skip after one");
    run(8'h00, 8'h05, cw(OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h03), 8'h08, 8'h00);
    run(8'h00, 8'h00, cw(OP_BIT_TEST, 1'b0, 3'h2, 7'h05, 8'h00), 8'h00, 8'h08);
    cmp({31'h0, skip_pending}, 32'h1, "skip after zero");
    run(8'h00, 8'h05, cw(OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h03), 8'h05, 8'h00);
    cmp({31'h0, skip_pending}, 32'h0, "skip cleared");
    // A write without the low byte lane must leave the register alone
    i_mst.wr(`ACCAL_OFF_ACC, 32'h5a, resp, 4'he);
    cmp({30'h0, resp}, {30'h0, `ACCAL_RESP_OKAY}, "masked write resp");
    chk(`ACCAL_OFF_ACC, 32'h05);
    chk(`ACCAL_OFF_CYC, 32'h1d);
    $display("test bit test done");
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    test_done;
  end
endmodule // tb_accum_alu_bit_ops
`default_nettype wire
